// ===== hw/fmu_defines.svh
// Opcode, field and constant definitions for the fractional multiply unit
`ifndef FMU_DEFINES_SVH
`define FMU_DEFINES_SVH
`define FMU_MAJOR_HI 31
`define FMU_MAJOR_LO 26
`define FMU_MAJOR_GROUP 6'h00
`define FMU_RT_HI 25
`define FMU_RT_LO 21
`define FMU_RS_HI 20
`define FMU_RS_LO 16
`define FMU_RD_HI 15
`define FMU_RD_LO 11
`define FMU_ZERO_BIT 10
`define FMU_MINOR_HI 9
`define FMU_MINOR_LO 0
`define FMU_MINOR_RND_WORD 10'h195
`define FMU_MINOR_SAT_WORD 10'h1D5
`define FMU_MINOR_SAT_HALF 10'h115
`define FMU_Q31_NEG_ONE 32'h80000000
`define FMU_Q31_MAX 32'h7FFFFFFF
`define FMU_Q15_NEG_ONE 16'h8000
`define FMU_Q15_MAX 16'h7FFF
`define FMU_RND_BIT31 64'h0000000080000000
`define FMU_OVF_BIT 21
`define FMU_CTRL_RESET 32'h00000000
`define FMU_RESULT_IDLE 32'h00000000
`define FMU_LANE_COUNT 2
`define FMU_LANE_WIDTH 16
`endif

// ===== hw/fmu_pkg.sv
// Types shared by the fractional multiply unit
package fmu_pkg;
  typedef enum logic [1:0] {
    FMU_OP_NONE = 2'b00,
    FMU_OP_RND_WORD = 2'b01,
    FMU_OP_SAT_WORD = 2'b10,
    FMU_OP_SAT_HALF = 2'b11
  } fmu_op_t;

  typedef struct packed {
    logic valid;
    logic [31:0] instr;
    logic [31:0] left_operand;
    logic [31:0] second_operand;
  } fmu_req_t;

  typedef struct packed {
    logic valid;
    logic [4:0] dest;
    logic [31:0] data;
    logic ovf;
  } fmu_res_t;
endpackage

// ===== hw/fmu_half_mul.sv
// One Q15 halfword lane of the saturating dual halfword multiply
`include "fmu_defines.svh"
module fmu_half_mul (
  input wire logic [15:0] i_a,
  input wire logic [15:0] i_b,
  output logic [15:0] o_res,
  output logic o_sat
);
  logic signed [31:0] prod;
  logic [31:0] shifted;

  // Shift the product into Q31, keep the upper half, saturate -1 * -1
  always_comb begin
    prod = $signed(i_a) * $signed(i_b);
    shifted = {prod[30:0], 1'b0};
    // RULE10: minus one squared saturates
    o_sat = (i_a == `FMU_Q15_NEG_ONE) && (i_b == `FMU_Q15_NEG_ONE);
    o_res = o_sat ? `FMU_Q15_MAX : shifted[31:16];
  end
endmodule

// ===== hw/fmu_unit.sv
// Fractional multiply unit datapath with overflow sticky bit
// Overview of operation
// RULE1: Decode rounded word multiply, fields as given
// RULE2: Rounded: product shifted, add bit31, upper
// RULE3: Rounded: minus one squared gives Q31 max
// RULE4: Word saturation sets overflow bit 21
// RULE5: Base accumulator may become undefined
// RULE6: Other three accumulators stay unchanged
// RULE7: Only reserved or extension-disabled exceptions
// RULE8: No operand-dependent exceptions ever raised
// RULE9: Halfword lanes shifted, upper half kept
// RULE10: Halfword minus one squared gives 0x7FFF
// RULE11: Either lane saturating sets bit 21
// RULE12: Decode unrounded word multiply likewise
// RULE13: Unrounded: shift, drop low word, upper
// RULE14: Unrounded: minus one squared gives Q31 max
// RULE15: Sticky bit only set, never cleared
`include "fmu_defines.svh"
module fmu_unit (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire fmu_pkg::fmu_req_t i_req,
  input wire logic i_ext_enable,
  input wire logic [31:0] i_ctrl_in,
  output fmu_pkg::fmu_res_t o_res,
  output logic [31:0] o_ctrl,
  output logic o_rsvd_instr_exc,
  output logic o_ext_disabled_exc,
  output logic o_base_acc_clobber
);
  import fmu_pkg::*;

  // Decode results
  fmu_op_t op;
  logic [5:0] major;
  logic [9:0] minor;
  logic zero_ok;
  logic known_op;
  // Word datapath
  logic signed [63:0] wprod;
  logic [63:0] wshift;
  logic [63:0] wrnd;
  logic word_sat;
  logic [31:0] rnd_word_res;
  logic [31:0] trunc_word_res;
  // Halfword lanes, index 1 is the upper lane
  logic [1:0][15:0] lane_res;
  logic [1:0] lane_sat;
  logic [31:0] half_res;
  logic half_sat;
  // Selected result and request status
  logic [31:0] result;
  logic sat_any;
  logic legal;
  // Next values of the registered outputs
  fmu_res_t next_res;
  logic [31:0] next_ctrl;
  logic next_rsvd;
  logic next_dis;
  logic next_clobber;

  // Opcode decode
  always_comb begin
    major = i_req.instr[`FMU_MAJOR_HI:`FMU_MAJOR_LO];
    minor = i_req.instr[`FMU_MINOR_HI:`FMU_MINOR_LO];
    zero_ok = (major == `FMU_MAJOR_GROUP) && !i_req.instr[`FMU_ZERO_BIT];
    op = FMU_OP_NONE;
    // RULE1: rounded word decode
    if (zero_ok && minor == `FMU_MINOR_RND_WORD) begin
      op = FMU_OP_RND_WORD;
    // RULE12: unrounded word decode
    end else if (zero_ok && minor == `FMU_MINOR_SAT_WORD) begin
      op = FMU_OP_SAT_WORD;
    end else if (zero_ok && minor == `FMU_MINOR_SAT_HALF) begin
      op = FMU_OP_SAT_HALF;
    end
  end

  // Two Q15 lanes, one multiplier each; lane 1 feeds the upper half
  for (genvar lane = 0; lane < `FMU_LANE_COUNT; lane = lane + 1) begin : g_lane
    fmu_half_mul u_half (
      .i_a(i_req.left_operand[lane*`FMU_LANE_WIDTH +: `FMU_LANE_WIDTH]),
      .i_b(i_req.second_operand[lane*`FMU_LANE_WIDTH +: `FMU_LANE_WIDTH]),
      .o_res(lane_res[lane]),
      .o_sat(lane_sat[lane])
    );
  end

  // Lanes packed back into their own halves
  always_comb begin
    // RULE9: lanes into matching halves
    half_res = {lane_res[1], lane_res[0]};
    // RULE11: either lane saturating
    half_sat = |lane_sat;
  end

  // Full signed product, moved into Q31 by one left shift
  always_comb begin
    wprod = $signed(i_req.left_operand) * $signed(i_req.second_operand);
    wshift = {wprod[62:0], 1'b0};
    // Minus one squared is the only product that does not fit
    word_sat = (i_req.left_operand == `FMU_Q31_NEG_ONE)
      && (i_req.second_operand == `FMU_Q31_NEG_ONE);
  end

  // Rounded variant: add one at bit 31, keep the upper word
  always_comb begin
    // RULE2: round at bit 31
    wrnd = wshift + `FMU_RND_BIT31;
    // RULE3: saturate, skip rounding
    rnd_word_res = word_sat ? `FMU_Q31_MAX : wrnd[63:32];
  end

  // Unrounded variant: the low word is simply dropped
  always_comb begin
    // RULE13: truncate without rounding
    // RULE14: saturate minus one squared
    trunc_word_res = word_sat ? `FMU_Q31_MAX : wshift[63:32];
  end

  // Result and saturation of the decoded operation
  always_comb begin
    result = `FMU_RESULT_IDLE;
    sat_any = 1'b0;
    case (op)
      FMU_OP_RND_WORD: begin
        result = rnd_word_res;
        sat_any = word_sat;
      end
      FMU_OP_SAT_WORD: begin
        result = trunc_word_res;
        sat_any = word_sat;
      end
      FMU_OP_SAT_HALF: begin
        // RULE10: lane saturation kept per lane
        result = half_res;
        sat_any = half_sat;
      end
      default: begin
        result = `FMU_RESULT_IDLE;
        sat_any = 1'b0;
      end
    endcase
  end

  // Only a known opcode with the extension enabled may run
  always_comb begin
    known_op = (op != FMU_OP_NONE);
    legal = i_req.valid && known_op && i_ext_enable;
  end

  // Result group: destination, data and saturation of a legal request
  always_comb begin
    // RULE1: destination from the result field
    next_res.valid = legal;
    next_res.dest = i_req.instr[`FMU_RD_HI:`FMU_RD_LO];
    next_res.data = result;
    next_res.ovf = legal && sat_any;
  end

  // Result registers, answer one cycle after the request
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_res <= '0;
    end else begin
      o_res <= next_res;
    end
  end

  // Exception group: decode and enable faults only
  always_comb begin
    // RULE7: only decode and enable faults
    next_rsvd = i_req.valid && !known_op;
    // RULE8: operands never raise exceptions
    next_dis = i_req.valid && known_op && !i_ext_enable;
  end

  // Exception pulses stand for one cycle
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_rsvd_instr_exc <= 1'b0;
      o_ext_disabled_exc <= 1'b0;
    end else begin
      o_rsvd_instr_exc <= next_rsvd;
      o_ext_disabled_exc <= next_dis;
    end
  end

  // Control group: the overflow bit is only ever set here
  always_comb begin
    next_ctrl = i_ctrl_in;
    // RULE4: saturation sets bit 21
    // RULE15: only ever set, never cleared
    if (legal && sat_any) begin
      next_ctrl[`FMU_OVF_BIT] = 1'b1;
    end
  end

  // Control value handed back for write-back every cycle
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_ctrl <= `FMU_CTRL_RESET;
    end else begin
      o_ctrl <= next_ctrl;
    end
  end

  // Accumulator group: only the base pair is marked as lost
  always_comb begin
    // RULE5: base accumulator may be lost
    // RULE6: no write path to other accumulators
    next_clobber = legal;
  end

  // Clobber pulse for the base accumulator
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_base_acc_clobber <= 1'b0;
    end else begin
      o_base_acc_clobber <= next_clobber;
    end
  end
endmodule

// ===== bench/fmu_pipe_model.sv
// Pipeline-side model of the control register write-back
module fmu_pipe_model (
  input wire logic [31:0] i_ctrl_wb,
  input wire logic i_clear,
  input wire logic [31:0] i_preset,
  output logic [31:0] o_ctrl_rd
);
  timeunit 1ns;
  timeprecision 1ps;
  // Register reads back what the unit wrote, or a preset while clearing
  assign o_ctrl_rd = i_clear ? i_preset : i_ctrl_wb;
endmodule

// ===== bench/fmu_unit_monitor.sv
// Port checker for the fractional multiply unit
module fmu_unit_monitor (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire fmu_pkg::fmu_req_t i_req,
  input wire logic i_ext_enable,
  input wire logic [31:0] i_ctrl_in,
  input wire fmu_pkg::fmu_res_t o_res,
  input wire logic [31:0] o_ctrl,
  input wire logic o_rsvd_instr_exc,
  input wire logic o_ext_disabled_exc,
  input wire logic o_base_acc_clobber
);
  timeunit 1ns;
  timeprecision 1ps;
  import fmu_pkg::*;
  logic [9:0] mn;
  logic known, go, m1, word_go, hi_m1;
  // Opcode recognition and minus-one operand pairs
  assign mn = i_req.instr[9:0];
  assign known = i_req.instr[31:26] == 6'h00 && !i_req.instr[10] &&
    (mn == 10'h195 || mn == 10'h1D5 || mn == 10'h115);
  assign go = i_req.valid && known && i_ext_enable;
  assign word_go = go && mn != 10'h115;
  assign m1 = i_req.left_operand == 32'h80000000 && i_req.second_operand == 32'h80000000;
  assign hi_m1 = i_req.left_operand[31:16] == 16'h8000 &&
    i_req.second_operand[31:16] == 16'h8000;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  res_dest_a: assert property (go |=>
    o_res.valid && o_res.dest == $past(i_req.instr[15:11]))
    else $error("result pulse or destination wrong");
  rsvd_exc_a: assert property (i_req.valid && !known |=>
    o_rsvd_instr_exc && !o_res.valid) else $error("unknown opcode not refused");
  dis_exc_a: assert property (i_req.valid && known && !i_ext_enable |=>
    o_ext_disabled_exc) else $error("disabled extension not refused");
  no_data_exc_a: assert property (go |=>
    !o_rsvd_instr_exc && !o_ext_disabled_exc) else $error("exception on legal request");
  word_sat_a: assert property (word_go && m1 |=>
    o_res.data == 32'h7FFFFFFF && o_ctrl[21]) else $error("word saturation wrong");
  word_ovf_a: assert property (word_go |=>
    o_res.ovf == $past(m1)) else $error("word overflow flag wrong");
  half_sat_a: assert property (go && mn == 10'h115 && hi_m1 |=>
    o_res.data[31:16] == 16'h7FFF && o_res.ovf && o_ctrl[21])
    else $error("halfword saturation wrong");
  sticky_keep_a: assert property (i_ctrl_in[21] |=> o_ctrl[21])
    else $error("sticky bit cleared");
  ctrl_follow_a: assert property (1'b1 |=>
    ((o_ctrl ^ $past(i_ctrl_in)) & 32'hFFDFFFFF) == 0) else $error("control bits not carried");
  refuse_keep_a: assert property (i_req.valid && !go && !i_ctrl_in[21] |=> !o_ctrl[21])
    else $error("refused request set sticky bit");
  base_clobber_a: assert property (o_base_acc_clobber == o_res.valid)
    else $error("base accumulator flag wrong");
  cover property (o_res.valid && o_res.ovf);
  cover property (o_rsvd_instr_exc);
  cover property (o_ext_disabled_exc);
  cover property (o_res.valid && !o_res.ovf && o_ctrl[21]);
endmodule
bind fmu_unit fmu_unit_monitor u_mon (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_req(i_req),
  .i_ext_enable(i_ext_enable), .i_ctrl_in(i_ctrl_in), .o_res(o_res), .o_ctrl(o_ctrl),
  .o_rsvd_instr_exc(o_rsvd_instr_exc), .o_ext_disabled_exc(o_ext_disabled_exc),
  .o_base_acc_clobber(o_base_acc_clobber));

// ===== bench/test_fractional_multiply_unit.sv
// Self-checking bench for the fractional multiply unit
module test_fractional_multiply_unit;
  timeunit 1ns;
  timeprecision 1ps;
  import fmu_pkg::*;
  logic clk, rst_n, en, clr, rsvd, dis, clob;
  logic [31:0] pre, ctrl_in, ctrl;
  fmu_req_t req;
  fmu_res_t res;
  int errors, n_tests, cyc;
  fmu_unit dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_req(req), .i_ext_enable(en),
    .i_ctrl_in(ctrl_in), .o_res(res), .o_ctrl(ctrl), .o_rsvd_instr_exc(rsvd),
    .o_ext_disabled_exc(dis), .o_base_acc_clobber(clob));
  fmu_pipe_model pipe (.i_ctrl_wb(ctrl), .i_clear(clr), .i_preset(pre), .o_ctrl_rd(ctrl_in));
  // Compare and count
  task chk(input logic [31:0] s, e);
    n_tests++;
    if (s !== e) begin
      errors++;
      $display("BAD %0t got %h want %h", $time, s, e);
    end
  endtask
  task complete_run;
    if (errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // One request, judged in the cycle its answer stands
  task automatic op(input logic [10:0] mn, input logic [31:0] a, b, d, ec,
    input logic v, ov, input logic [1:0] ex);
    req = '{1'b1, {6'h00, 5'h03, 5'h02, 5'h09, mn}, a, b};
    @(negedge clk);
    req.valid = 1'b0;
    chk({28'h0, res.valid, clob, rsvd, dis}, {28'h0, v, v, ex});
    chk(ctrl, ec);
    if (v) begin
      chk({26'h0, res.dest, res.ovf}, {26'h0, 5'h09, ov});
      chk(res.data, d);
    end
    @(negedge clk);
  endtask
  task t_word;
    op(10'h195, 32'h80000000, 32'h80000000, 32'h7FFFFFFF, 32'h0020A5A5, 1, 1, 0);
    op(10'h195, 32'h00000001, 32'h40000000, 32'h00000001, 32'h0000A5A5, 1, 0, 0);
    op(10'h1D5, 32'h00000001, 32'h40000000, 32'h00000000, 32'h0000A5A5, 1, 0, 0);
    clr = 1'b0;
    op(10'h1D5, 32'h80000000, 32'h80000000, 32'h7FFFFFFF, 32'h0020A5A5, 1, 1, 0);
    op(10'h1D5, 32'h40000000, 32'h40000000, 32'h20000000, 32'h0020A5A5, 1, 0, 0);
  endtask
  task t_half;
    clr = 1'b1;
    op(10'h115, 32'h8000C000, 32'h80004000, 32'h7FFFE000, 32'h0020A5A5, 1, 1, 0);
    op(10'h115, 32'h40008000, 32'h80004000, 32'hC000C000, 32'h0000A5A5, 1, 0, 0);
  endtask
  task t_refuse;
    en = 1'b0;
    op(10'h195, 32'h80000000, 32'h80000000, 0, 32'h0000A5A5, 0, 0, 2'b01);
    en = 1'b1;
    op(10'h3FF, 32'h80000000, 32'h80000000, 0, 32'h0000A5A5, 0, 0, 2'b10);
    op(11'h595, 32'h80000000, 32'h80000000, 0, 32'h0000A5A5, 0, 0, 2'b10);
  endtask
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 500) begin
      errors++;
      complete_run;
    end
  end
  initial begin
    rst_n = 0;
    req = '0;
    en = 1;
    clr = 1;
    pre = 32'h0000A5A5;
    repeat (2) @(negedge clk);
    rst_n = 1;
    @(negedge clk);
    t_word;
    t_half;
    t_refuse;
    complete_run;
  end
endmodule
